/* File: core/rtcc_map.vh */
// How it works
// - Mode field 0x0 wide counter, 0x1 narrow counter, 0x2 calendar, 0x3 reserved.
// - Mode field takes effect at once and raises no busy flag.
// - Written enable reads back at once; a change of enable raises the enable busy flag; core follows later.
//   The code starts no new handshake for a change written while that flag is already up.
// - Enable busy flag falls only after the core domain has acted.
// - Enable one means running, zero means stopped.
// - Writing zero to the soft reset bit changes nothing.
// - Soft reset restores all registers but debug control and leaves block disabled.
// - A write that sets soft reset discards every other field in it.
// - Soft reset bit reads one while in progress and clears itself when done.
// - Enable and soft reset cross into the core domain through synchronizers; the mode field crosses without one.
// - Each synchronized bit has its own synchronizer and own busy bit.
`ifndef RTCC_MAP_VH
`define RTCC_MAP_VH

// Fields of primary_control_reg.
`define RTCC_SOFT_RESET_BIT 0
`define RTCC_ENABLE_BIT 1
`define RTCC_MODE_LSB 2
`define RTCC_MODE_MSB 3
`define RTCC_CTRL_RESET 16'h0000

// Operating modes.
`define RTCC_MODE_WIDE 2'h0
`define RTCC_MODE_NARROW 2'h1
`define RTCC_MODE_CAL 2'h2
`define RTCC_MODE_RSVD 2'h3

// Bits of sync_pending_flags.
`define RTCC_SYNC_SOFT_RESET_BIT 0
`define RTCC_SYNC_ENABLE_BIT 1

// Core clock enable divider: one core tick every this many mclk cycles.
`define RTCC_CORE_DIV 4

`endif

/* File: core/rtcc_hs_chan.v */
`timescale 1ns/100ps
// One request/acknowledge channel between the bus domain and the core domain.
// The core domain is the mclk domain gated by core_tick, so the core-side
// flops only move on ticks, just as they would on a slow generic clock.
module rtcc_hs_chan (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    input wire core_tick,
    // Bus side
    input wire start,
    output reg busy,
    output reg done,
    // Core side
    output wire core_fire
);
    reg req_r;
    reg req_s1_r;
    reg req_s2_r;
    reg ack_r;
    reg ack_s1_r;
    reg ack_s2_r;
    wire busy_nxt;

    // The core acts once per request, on the tick where the request first lands.
    assign core_fire = core_tick & req_s2_r & ~ack_r;

    // Four-phase handshake: busy holds until the acknowledge has dropped again,
    // so a new request can never overlap the tail of the previous one.
    assign busy_nxt = req_r | ack_s2_r;

    always @(posedge mclk) begin
        if (!resetn) begin
            req_r <= 1'b0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            ack_s1_r <= ack_r;
            ack_s2_r <= ack_s1_r;
            if (start && !busy) begin
                req_r <= 1'b1;
            end else if (ack_s2_r) begin
                req_r <= 1'b0;
            end
            busy <= busy_nxt | (start & ~busy);
            done <= busy & ~busy_nxt & ~start;
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            ack_r <= 1'b0;
        end else if (core_tick) begin
            req_s1_r <= req_r;
            req_s2_r <= req_s1_r;
            ack_r <= req_s2_r;
        end
    end
endmodule // rtcc_hs_chan

/* File: core/rtcc_ctrl.v */
`timescale 1ns/100ps
`include "rtcc_map.vh"
// Primary control register with mode, enable and soft reset, handing enable
// and reset over to the counting core through separate handshake channels.
module rtcc_ctrl #(
    parameter CORE_DIV = `RTCC_CORE_DIV
) (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Register port
    input wire ctrl_wr,
    input wire [15:0] ctrl_wdata,
    input wire dbg_wr,
    input wire dbg_wdata,
    // Register readback
    output reg [15:0] ctrl_rdata,
    output reg [1:0] sync_pending_flags,
    output reg debug_run,
    // Core view
    output reg core_running,
    output reg [1:0] core_mode,
    output reg core_reset_pulse
);
    // Handshake channel numbers double as their bit positions in sync_pending_flags.
    localparam CH_RST = `RTCC_SYNC_SOFT_RESET_BIT;
    localparam CH_EN = `RTCC_SYNC_ENABLE_BIT;
    localparam NUM_CH = 2;
    localparam [15:0] CTRL_RESET = `RTCC_CTRL_RESET;

    reg [1:0] mode_r;
    reg [1:0] mode_nxt;
    reg enable_r;
    reg enable_nxt;
    reg soft_reset_r;
    reg soft_reset_nxt;
    reg [15:0] ctrl_rdata_nxt;
    reg [7:0] div_r;
    reg core_tick_r;
    reg core_run_r;
    wire wr_soft_reset;
    wire wr_normal;
    wire [NUM_CH-1:0] ch_start;
    wire [NUM_CH-1:0] ch_busy;
    wire [NUM_CH-1:0] ch_done;
    wire [NUM_CH-1:0] ch_fire;
    wire unused_en_done;
    genvar g;

    // A write is taken only while no soft reset is in flight; the soft reset
    // bit then decides which of the two kinds of write it is.
    function write_kind;
        input wr;
        input pending;
        input reset_bit;
        input want_reset;
        begin
            write_kind = wr & ~pending & (reset_bit == want_reset);
        end
    endfunction

    // A soft reset write carries nothing else, so its other fields are dropped here.
    assign wr_soft_reset = write_kind(ctrl_wr, soft_reset_r,
        ctrl_wdata[`RTCC_SOFT_RESET_BIT], 1'b1);
    assign wr_normal = write_kind(ctrl_wr, soft_reset_r,
        ctrl_wdata[`RTCC_SOFT_RESET_BIT], 1'b0);

    // Core clock enable: one tick every CORE_DIV cycles. The divider is eight bits
    // wide, so CORE_DIV must stay between 1 and 256.
    always @(posedge mclk) begin
        if (!resetn) begin
            div_r <= 8'h00;
            core_tick_r <= 1'b0;
        end else if (div_r == CORE_DIV[7:0] - 8'h01) begin
            div_r <= 8'h00;
            core_tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 8'h01;
            core_tick_r <= 1'b0;
        end
    end

    // Only a change of the enable bit needs the core to act; writing the value
    // already held costs no handshake and raises no busy flag.
    assign ch_start[CH_EN] = wr_normal & (ctrl_wdata[`RTCC_ENABLE_BIT] != enable_r);
    assign ch_start[CH_RST] = wr_soft_reset;

    // One channel per synchronized bit, each with its own busy flag.
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : g_chan
            rtcc_hs_chan u_chan (
                .mclk(mclk),
                .resetn(resetn),
                .core_tick(core_tick_r),
                .start(ch_start[g]),
                .busy(ch_busy[g]),
                .done(ch_done[g]),
                .core_fire(ch_fire[g])
            );
        end
    endgenerate

    // Bus-side next state. A completed soft reset outranks everything, and no
    // write can meet it in the same cycle because writes are refused meanwhile.
    always @* begin
        mode_nxt = mode_r;
        enable_nxt = enable_r;
        soft_reset_nxt = soft_reset_r;
        if (ch_done[CH_RST]) begin
            mode_nxt = CTRL_RESET[`RTCC_MODE_MSB:`RTCC_MODE_LSB];
            enable_nxt = CTRL_RESET[`RTCC_ENABLE_BIT];
            soft_reset_nxt = 1'b0;
        end else if (wr_soft_reset) begin
            soft_reset_nxt = 1'b1;
        end else if (wr_normal) begin
            // The mode is not synchronized, so it is live from this write on.
            mode_nxt = ctrl_wdata[`RTCC_MODE_MSB:`RTCC_MODE_LSB];
            enable_nxt = ctrl_wdata[`RTCC_ENABLE_BIT];
        end
    end

    // Bus-side registers.
    always @(posedge mclk) begin
        if (!resetn) begin
            mode_r <= CTRL_RESET[`RTCC_MODE_MSB:`RTCC_MODE_LSB];
        end else begin
            mode_r <= mode_nxt;
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            enable_r <= CTRL_RESET[`RTCC_ENABLE_BIT];
        end else begin
            enable_r <= enable_nxt;
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            soft_reset_r <= CTRL_RESET[`RTCC_SOFT_RESET_BIT];
        end else begin
            soft_reset_r <= soft_reset_nxt;
        end
    end

    // Debug control survives the soft reset; of the two resets, only the hard reset clears it.
    always @(posedge mclk) begin
        if (!resetn) begin
            debug_run <= 1'b0;
        end else if (dbg_wr) begin
            debug_run <= dbg_wdata;
        end
    end

    // Core-domain state moves only on core ticks, when a handshake lands.
    // The enable value is not held while its channel is busy, since only a soft reset
    // refuses writes; it is sampled here as it stands on the tick the handshake lands.
    always @(posedge mclk) begin
        if (!resetn) begin
            core_run_r <= 1'b0;
            core_reset_pulse <= 1'b0;
        end else begin
            core_reset_pulse <= ch_fire[CH_RST];
            if (ch_fire[CH_RST]) begin
                core_run_r <= 1'b0;
            end else if (ch_fire[CH_EN]) begin
                core_run_r <= enable_r;
            end
        end
    end

    // Readback word, laid out by the field positions.
    always @* begin
        ctrl_rdata_nxt = 16'h0000;
        ctrl_rdata_nxt[`RTCC_MODE_MSB:`RTCC_MODE_LSB] = mode_r;
        ctrl_rdata_nxt[`RTCC_ENABLE_BIT] = enable_r;
        ctrl_rdata_nxt[`RTCC_SOFT_RESET_BIT] = soft_reset_r;
    end

    // Outputs, each straight from its own flip-flop.
    always @(posedge mclk) begin
        if (!resetn) begin
            ctrl_rdata <= CTRL_RESET;
        end else begin
            ctrl_rdata <= ctrl_rdata_nxt;
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            sync_pending_flags <= 2'h0;
        end else begin
            sync_pending_flags <= ch_busy;
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            core_running <= 1'b0;
        end else begin
            core_running <= core_run_r;
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            core_mode <= CTRL_RESET[`RTCC_MODE_MSB:`RTCC_MODE_LSB];
        end else begin
            core_mode <= mode_r;
        end
    end

    // The enable channel needs no completion strobe: its busy flag says it all.
    assign unused_en_done = ch_done[CH_EN];
endmodule // rtcc_ctrl

/* File: verif/rtcc_ctrl_sva.sv */
`timescale 1ns/100ps
module rtcc_ctrl_sva (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Register port
    input wire ctrl_wr,
    input wire [15:0] ctrl_wdata,
    input wire dbg_wr,
    input wire dbg_wdata,
    // Readback and core view
    input wire [15:0] ctrl_rdata,
    input wire [1:0] sync_pending_flags,
    input wire debug_run,
    input wire core_running,
    input wire [1:0] core_mode,
    input wire core_reset_pulse
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Writes are judged against readback, so they must be spaced at least two cycles apart.
    wire idle = !ctrl_rdata[0] && sync_pending_flags == 2'h0;
    wire w0 = ctrl_wr && !ctrl_wdata[0] && idle;
    wire ws = ctrl_wr && ctrl_wdata[0] && idle;
    wire ch = ctrl_wdata[1] != ctrl_rdata[1];
    a_mode_direct: assert property (w0 |-> ##2 core_mode == $past(ctrl_wdata[3:2], 2))
        else $error("mode not applied");
    a_mode_no_busy: assert property (w0 && !ch |-> ##2 sync_pending_flags == 2'h0)
        else $error("mode write raised busy");
    a_enable_readback: assert property (w0 |-> ##2 ctrl_rdata[1] == $past(ctrl_wdata[1], 2))
        else $error("enable readback late");
    a_enable_busy: assert property (w0 && ch |-> ##2 sync_pending_flags == 2'h2)
        else $error("enable busy not set");
    a_busy_after_core: assert property (
        $fell(sync_pending_flags[1]) && !ctrl_rdata[0] |-> core_running == ctrl_rdata[1])
        else $error("busy fell before core");
    a_core_synced: assert property ($rose(sync_pending_flags[1]) |-> $stable(core_running)[*2])
        else $error("core changed unsynchronized");
    a_zero_no_reset: assert property (w0 |-> (!core_reset_pulse)[*4] ##0 !ctrl_rdata[0])
        else $error("zero started reset");
    a_reset_discard: assert property (
        ws |-> ##2 ctrl_rdata[0] && sync_pending_flags == 2'h1
        && core_mode == $past(core_mode, 2))
        else $error("reset write fields used");
    a_reset_done: assert property (
        $fell(ctrl_rdata[0]) |-> ctrl_rdata == 16'h0000
        && !sync_pending_flags[0] && !core_running && core_mode == 2'h0)
        else $error("reset left state");
    a_reset_bound: assert property ($rose(ctrl_rdata[0]) |-> ##[1:200] !ctrl_rdata[0])
        else $error("reset never cleared");
    c_reset: cover property ($fell(ctrl_rdata[0]));
    c_enable: cover property ($rose(core_running));
    c_busy: cover property ($fell(sync_pending_flags[1]));
endmodule // rtcc_ctrl_sva
bind rtcc_ctrl rtcc_ctrl_sva u_sva (
    .mclk(mclk),
    .resetn(resetn),
    .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata),
    .dbg_wr(dbg_wr),
    .dbg_wdata(dbg_wdata),
    .ctrl_rdata(ctrl_rdata),
    .sync_pending_flags(sync_pending_flags),
    .debug_run(debug_run),
    .core_running(core_running),
    .core_mode(core_mode),
    .core_reset_pulse(core_reset_pulse)
);

/* File: verif/tb_rtcc_ctrl.sv */
`timescale 1ns/100ps
module tb_rtcc_ctrl;
    reg mclk = 1'b0;
    reg resetn, ctrl_wr, dbg_wr, dbg_wdata;
    reg [15:0] ctrl_wdata;
    wire [15:0] ctrl_rdata;
    wire [1:0] sync_pending_flags, core_mode;
    wire debug_run, core_running, core_reset_pulse;
    wire [21:0] st = {debug_run, core_running, core_mode, sync_pending_flags, ctrl_rdata};
    integer fails = 0;
    integer check_count = 0;
    integer i, m;
    rtcc_ctrl u_dut (.mclk(mclk), .resetn(resetn), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata),
        .ctrl_rdata(ctrl_rdata), .sync_pending_flags(sync_pending_flags),
        .debug_run(debug_run), .core_running(core_running), .core_mode(core_mode),
        .core_reset_pulse(core_reset_pulse));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task chk(input [21:0] seen, input [21:0] want);
        begin
            check_count = check_count + 1;
            if (seen !== want) begin
                fails = fails + 1;
                $display("wrong value at %0t seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task wr(input [15:0] d);
        begin
            ctrl_wr = 1'b1;
            ctrl_wdata = d;
            @(negedge mclk);
            ctrl_wr = 1'b0;
            repeat (2) @(negedge mclk);
        end
    endtask
    // Both busy flags and the reset bit must read zero before a dependent write.
    task poll;
        begin
            for (i = 0; i < 300 && (sync_pending_flags !== 2'h0 || ctrl_rdata[0] !== 1'b0);
                    i = i + 1)
                @(negedge mclk);
            // A poll that runs out of time counts against the run.
            if (i == 300)
                fails = fails + 1;
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d fails %0d", check_count, fails);
            if (fails == 0 && check_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        #200000;
        fails = fails + 1;
        end_of_test;
    end
    initial begin
        resetn = 1'b0;
        ctrl_wr = 1'b0;
        ctrl_wdata = 16'h0000;
        dbg_wr = 1'b0;
        dbg_wdata = 1'b0;
        repeat (16) @(negedge mclk);
        resetn = 1'b1;
        chk(st, 22'h0);
        for (m = 0; m < 4; m = m + 1) begin
            wr({12'h0, m[1:0], 2'h0});
            chk(st, {2'b00, m[1:0], 2'h0, 12'h0, m[1:0], 2'h0});
        end
        $display("mode test done");
        wr(16'h0006);
        chk(st, {2'b00, 2'h1, 2'h2, 16'h0006});
        poll;
        chk(st, {2'b01, 2'h1, 2'h0, 16'h0006});
        wr(16'h0004);
        poll;
        chk(st, {2'b00, 2'h1, 2'h0, 16'h0004});
        $display("enable test done");
        dbg_wr = 1'b1;
        dbg_wdata = 1'b1;
        @(negedge mclk);
        dbg_wr = 1'b0;
        wr(16'h000a);
        poll;
        chk(st, {2'b11, 2'h2, 2'h0, 16'h000a});
        wr(16'h000f);
        chk({20'h0, ctrl_rdata[0], sync_pending_flags[0]}, 22'h3);
        chk(st, {2'b11, 2'h2, 2'h1, 16'h000b});
        wr(16'h0004);
        poll;
        chk(st, {2'b10, 2'h0, 2'h0, 16'h0000});
        $display("reset test done");
        resetn = 1'b0;
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        chk(st, 22'h0);
        wr(16'h0002);
        poll;
        chk(st, {2'b01, 2'h0, 2'h0, 16'h0002});
        $display("hard reset test done");
        end_of_test;
    end
endmodule // tb_rtcc_ctrl
